// ### disp_pkg.sv
// constants and types shared by the dual serial slave ports
package disp_pkg;

  localparam logic [6:0] CHAN_DEV_ADDR       = 7'h74;
  localparam logic [6:0] LINK_CTRL_ADDR_LO   = 7'h60;
  localparam logic [6:0] LINK_CTRL_ADDR_HI   = 7'h62;
  localparam logic [6:0] LOW_LEVEL_ADDR_LO   = 7'h68;
  localparam logic [6:0] LOW_LEVEL_ADDR_HI   = 7'h6a;

  // channel port pointer home: the link integrity value
  localparam logic [7:0] CHAN_PTR_RESET      = 8'h08;
  localparam logic [3:0] LIV_LSB_OFFSET      = 4'h8;
  localparam logic [3:0] LIV_MSB_OFFSET      = 4'h9;

  // relocatable addresses held in the link control group
  localparam logic [2:0] CONSUMER_ADDR_OFFSET   = 3'h0;
  localparam logic [2:0] DISPLAY_ID_ADDR_OFFSET = 3'h1;
  localparam logic [2:0] EXT_COLOUR_ADDR_OFFSET = 3'h2;
  localparam logic [7:0] CONSUMER_ADDR_RESET    = 8'h34;
  localparam logic [7:0] DISPLAY_ID_ADDR_RESET  = 8'h50;
  localparam logic [7:0] EXT_COLOUR_ADDR_RESET  = 8'h32;

  // low-level group
  localparam logic [2:0] LOW_STATUS_OFFSET   = 3'h0;
  localparam logic [2:0] LOW_SOFT_RST_OFFSET = 3'h1;
  localparam int         SYNC_DETECT_BIT     = 0;
  localparam int         CLOCK_DETECT_BIT    = 1;
  localparam int         SOFT_RESET_BIT      = 0;

  localparam logic [2:0] GRP_LINK_CTRL       = 3'h0;
  localparam logic [2:0] GRP_LOW_LEVEL       = 3'h1;
  localparam logic [2:0] GRP_CONSUMER        = 3'h2;
  localparam logic [2:0] GRP_DISPLAY_ID      = 3'h3;
  localparam logic [2:0] GRP_EXT_COLOUR      = 3'h4;
  localparam int         GROUP_COUNT         = 5;
  localparam int         GROUP_BYTES         = 8;
  localparam int         CHAN_BYTES          = 16;

  localparam logic [3:0] BITS_PER_BYTE       = 4'h8;

  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_REG, ST_REG_ACK, ST_WDATA,
    ST_WACK, ST_RDATA, ST_RACK, ST_RNEXT, ST_WAIT
  } disp_state_e;

endpackage : disp_pkg

// ### disp_i2c_engine.sv
// byte-level serial slave engine with register pointer
`timescale 1ns/1ps
module disp_i2c_engine
  import disp_pkg::*;
#(
  parameter bit         SHORT_READ = 1'b0,
  parameter logic [7:0] PTR_INIT   = 8'h00,
  parameter bit         PTR_RELOAD = 1'b0
) (
  input  wire logic       core_clk_i,
  input  wire logic       reset_i,
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  input  wire logic       soft_reset_i,
  input  wire logic       addr_hit_i,
  input  wire logic [7:0] rdata_i,
  output logic      [6:0] dev_addr_o,
  output logic            addr_take_o,
  output logic            wr_stb_o,
  output logic            rd_stb_o,
  output logic      [7:0] ptr_o,
  output logic      [7:0] wdata_o,
  output logic            sda_oe_o
);

  disp_state_e state_reg;
  logic [3:0]  cnt_reg;
  logic [7:0]  shreg_reg;
  logic        rw_reg;
  logic        ptr_ok_reg;
  logic        scl_d_reg;
  logic        sda_d_reg;
  logic        scl_rise;
  logic        scl_fall;
  logic        start_seen;
  logic        stop_seen;

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      scl_d_reg <= scl_i;
      sda_d_reg <= sda_i;
    end
  end

  assign scl_rise   = scl_i & ~scl_d_reg;
  assign scl_fall   = ~scl_i & scl_d_reg;
  assign start_seen = scl_i & scl_d_reg & sda_d_reg & ~sda_i;
  assign stop_seen  = scl_i & scl_d_reg & ~sda_d_reg & sda_i;
  assign dev_addr_o = shreg_reg[7:1];

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      state_reg   <= ST_IDLE;
      cnt_reg     <= 4'h0;
      shreg_reg   <= 8'h00;
      rw_reg      <= 1'b0;
      ptr_o       <= PTR_INIT;
      ptr_ok_reg  <= 1'b0;
      sda_oe_o    <= 1'b0;
      addr_take_o <= 1'b0;
      wr_stb_o    <= 1'b0;
      rd_stb_o    <= 1'b0;
      wdata_o     <= 8'h00;
    end else begin
      addr_take_o <= 1'b0;
      wr_stb_o    <= 1'b0;
      rd_stb_o    <= 1'b0;
      if (start_seen) begin
        state_reg <= ST_ADDR;
        cnt_reg   <= 4'h0;
        sda_oe_o  <= 1'b0;
      end else if (stop_seen) begin
        state_reg  <= ST_IDLE;
        sda_oe_o   <= 1'b0;
        ptr_ok_reg <= 1'b0;
        if (PTR_RELOAD) begin
          ptr_o <= PTR_INIT;
        end
      end else if (scl_rise) begin
        case (state_reg)
          ST_ADDR, ST_REG, ST_WDATA: begin
            shreg_reg <= {shreg_reg[6:0], sda_i};
            cnt_reg   <= cnt_reg + 4'h1;
          end
          // a high level in the acknowledge slot ends the read
          ST_RACK: state_reg <= sda_i ? ST_WAIT : ST_RNEXT;
          default: ;
        endcase
      end else if (scl_fall) begin
        case (state_reg)
          ST_ADDR: begin
            if (cnt_reg == BITS_PER_BYTE) begin
              rw_reg <= shreg_reg[0];
              // reads with no pointer phase only where allowed
              if (addr_hit_i && (SHORT_READ || !shreg_reg[0] ||
                  ptr_ok_reg)) begin
                addr_take_o <= 1'b1;
                sda_oe_o    <= 1'b1;
                state_reg   <= ST_ADDR_ACK;
              end else begin
                state_reg <= ST_WAIT;
              end
            end
          end
          ST_ADDR_ACK, ST_RNEXT: begin
            if (state_reg == ST_RNEXT || rw_reg) begin
              sda_oe_o  <= ~rdata_i[7];
              shreg_reg <= {rdata_i[6:0], 1'b0};
              cnt_reg   <= 4'h1;
              state_reg <= ST_RDATA;
            end else begin
              sda_oe_o  <= 1'b0;
              cnt_reg   <= 4'h0;
              state_reg <= ST_REG;
            end
          end
          ST_REG: begin
            if (cnt_reg == BITS_PER_BYTE) begin
              ptr_o      <= shreg_reg;
              ptr_ok_reg <= 1'b1;
              sda_oe_o   <= 1'b1;
              state_reg  <= ST_REG_ACK;
            end
          end
          ST_REG_ACK, ST_WACK: begin
            if (state_reg == ST_WACK) begin
              ptr_o <= ptr_o + 8'h01;
            end
            sda_oe_o  <= 1'b0;
            cnt_reg   <= 4'h0;
            state_reg <= ST_WDATA;
          end
          ST_WDATA: begin
            if (cnt_reg == BITS_PER_BYTE) begin
              wr_stb_o  <= 1'b1;
              wdata_o   <= shreg_reg;
              sda_oe_o  <= 1'b1;
              state_reg <= ST_WACK;
            end
          end
          ST_RDATA: begin
            if (cnt_reg == BITS_PER_BYTE) begin
              sda_oe_o  <= 1'b0;
              rd_stb_o  <= 1'b1;
              ptr_o     <= ptr_o + 8'h01;
              state_reg <= ST_RACK;
            end else begin
              sda_oe_o  <= ~shreg_reg[7];
              shreg_reg <= {shreg_reg[6:0], 1'b0};
              cnt_reg   <= cnt_reg + 4'h1;
            end
          end
          default: ;
        endcase
      end
      if (soft_reset_i) begin
        ptr_o <= PTR_INIT;
      end
    end
  end

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (reset_i);

  sequence s_addr_byte_done;
    state_reg == ST_ADDR && scl_fall && cnt_reg == BITS_PER_BYTE;
  endsequence

  sequence s_frame_stop;
    stop_seen && !soft_reset_i;
  endsequence

  AST_PTR_RELOAD: assert property (
    PTR_RELOAD && stop_seen |=> ptr_o == PTR_INIT)
    else $error("pointer not restored after stop");

  AST_PTR_STEP: assert property (
    rd_stb_o && !$past(soft_reset_i) |-> ptr_o == $past(ptr_o) + 8'h01)
    else $error("pointer did not step after a read byte");

  AST_ACK_ON_TAKE: assert property (
    addr_take_o |-> sda_oe_o ##1 (sda_oe_o || start_seen || stop_seen))
    else $error("address acknowledge not held");

  AST_NO_FOREIGN_ACK: assert property (
    s_addr_byte_done ##0 !addr_hit_i |=> !sda_oe_o && state_reg == ST_WAIT)
    else $error("acknowledged an address that is not ours");

  AST_NO_BARE_READ: assert property (
    addr_take_o && rw_reg |-> SHORT_READ || ptr_ok_reg)
    else $error("read without pointer phase accepted");

  AST_WRITE_ACK: assert property (
    wr_stb_o |-> sda_oe_o && state_reg == ST_WACK)
    else $error("write byte not acknowledged");

  AST_STOP_IDLE: assert property (
    s_frame_stop |=> state_reg == ST_IDLE && !sda_oe_o)
    else $error("data line held after stop");

endmodule : disp_i2c_engine

// ### disp_i2c_ports.sv
// dual serial slave ports: data channel port and local configuration port
//
// What this block does
// - Channel port answers device address 0x74.
// - Transfers carry any number of data bytes.
// - Acknowledge every byte except final read byte.
// - Pointer steps per byte, low byte first.
// - Channel port supports reads without pointer phase.
// - Channel pointer returns to 0x08 on resets, stop.
// - Local port is separate slave, own pins.
// - Local port refuses reads without pointer phase.
// - Local port works up to 400 kHz.
// - Local port decodes five separate device addresses.
// - Strap picks 0x60/0x68 or 0x62/0x6A.
// - Strap addresses frozen after reset.
// - Three local addresses held in writable registers.
// - Registers work without video clock present.
`timescale 1ns/1ps
module disp_i2c_ports
  import disp_pkg::*;
(
  input  wire logic        core_clk_i,
  input  wire logic        reset_i,
  input  wire logic        address_strap_pin_i,
  input  wire logic        channel_serial_clock_pin_i,
  input  wire logic        channel_serial_data_pin_i,
  output logic             channel_serial_data_pin_o,
  output logic             channel_serial_data_pin_oe_o,
  input  wire logic        local_serial_clock_pin_i,
  input  wire logic        local_serial_data_pin_i,
  output logic             local_serial_data_pin_o,
  output logic             local_serial_data_pin_oe_o,
  input  wire logic [15:0] link_integrity_value_i,
  input  wire logic        sync_detect_flag_i,
  input  wire logic        clock_detect_flag_i
);

  localparam int SYNC_W = 7;

  // every foreign level except link_integrity_value_i passes two flops; the first is read by nothing else
  logic [SYNC_W-1:0] meta_reg;
  logic [SYNC_W-1:0] sync_reg;
  logic              strap_s;
  logic              chan_scl_s;
  logic              chan_sda_s;
  logic              loc_scl_s;
  logic              loc_sda_s;
  logic              sync_det_s;
  logic              clk_det_s;

  // no reset here: the strap must already be through both flops when
  // reset lifts, or the latch below would catch a reset constant
  always_ff @(posedge core_clk_i) begin
    meta_reg <= {address_strap_pin_i, channel_serial_clock_pin_i,
                 channel_serial_data_pin_i, local_serial_clock_pin_i,
                 local_serial_data_pin_i, sync_detect_flag_i,
                 clock_detect_flag_i};
    sync_reg <= meta_reg;
  end

  assign {strap_s, chan_scl_s, chan_sda_s, loc_scl_s, loc_sda_s,
          sync_det_s, clk_det_s} = sync_reg;

  // strap is caught once, in the first cycle after reset release
  logic strap_reg;
  logic strap_done_reg;

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      strap_reg      <= 1'b0;
      strap_done_reg <= 1'b0;
    end else if (!strap_done_reg) begin
      strap_reg      <= strap_s;
      strap_done_reg <= 1'b1;
    end
  end

  function automatic logic [5:0] mem_index(input logic [2:0] grp,
                                           input logic [2:0] off);
    mem_index = {grp, off};
  endfunction : mem_index

  logic [7:0] local_mem_reg [0:GROUP_COUNT*GROUP_BYTES-1];
  logic [7:0] chan_mem_reg  [0:CHAN_BYTES-1];
  logic       soft_reset_reg;

  // data channel port
  logic [6:0] chan_dev;
  logic       chan_take;
  logic       chan_wr;
  logic [7:0] chan_ptr;
  logic [7:0] chan_wdata;
  logic [7:0] chan_rdata;

  always_comb begin
    if (chan_ptr[3:0] == LIV_LSB_OFFSET) begin
      chan_rdata = link_integrity_value_i[7:0];
    end else if (chan_ptr[3:0] == LIV_MSB_OFFSET) begin
      chan_rdata = link_integrity_value_i[15:8];
    end else begin
      chan_rdata = chan_mem_reg[chan_ptr[3:0]];
    end
  end

  disp_i2c_engine #(
    .SHORT_READ (1'b1),
    .PTR_INIT   (CHAN_PTR_RESET),
    .PTR_RELOAD (1'b1)
  ) u_chan (
    .core_clk_i   (core_clk_i),
    .reset_i      (reset_i),
    .scl_i        (chan_scl_s),
    .sda_i        (chan_sda_s),
    .soft_reset_i (soft_reset_reg),
    .addr_hit_i   (chan_dev == CHAN_DEV_ADDR),
    .rdata_i      (chan_rdata),
    .dev_addr_o   (chan_dev),
    .addr_take_o  (chan_take),
    .wr_stb_o     (chan_wr),
    .rd_stb_o     (),
    .ptr_o        (chan_ptr),
    .wdata_o      (chan_wdata),
    .sda_oe_o     (channel_serial_data_pin_oe_o)
  );

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      for (int i = 0; i < CHAN_BYTES; i++) begin
        chan_mem_reg[i] <= 8'h00;
      end
    end else if (chan_wr) begin
      chan_mem_reg[chan_ptr[3:0]] <= chan_wdata;
    end
  end

  // local configuration port, on its own pins
  logic [6:0] loc_dev;
  logic       loc_take;
  logic       loc_wr;
  logic [7:0] loc_ptr;
  logic [7:0] loc_wdata;
  logic [7:0] loc_rdata;
  logic       loc_hit;
  logic [2:0] loc_hit_grp;
  logic [2:0] loc_grp_reg;
  logic [6:0] link_ctrl_addr;
  logic [6:0] low_level_addr;

  assign link_ctrl_addr = strap_reg ? LINK_CTRL_ADDR_HI
                                    : LINK_CTRL_ADDR_LO;
  assign low_level_addr = strap_reg ? LOW_LEVEL_ADDR_HI
                                    : LOW_LEVEL_ADDR_LO;

  // first match wins if software moves two addresses onto one value
  always_comb begin
    loc_hit     = 1'b1;
    loc_hit_grp = GRP_LINK_CTRL;
    if (loc_dev == link_ctrl_addr) begin
      loc_hit_grp = GRP_LINK_CTRL;
    end else if (loc_dev == low_level_addr) begin
      loc_hit_grp = GRP_LOW_LEVEL;
    end else if (loc_dev == local_mem_reg[mem_index(GRP_LINK_CTRL,
                 CONSUMER_ADDR_OFFSET)][6:0]) begin
      loc_hit_grp = GRP_CONSUMER;
    end else if (loc_dev == local_mem_reg[mem_index(GRP_LINK_CTRL,
                 DISPLAY_ID_ADDR_OFFSET)][6:0]) begin
      loc_hit_grp = GRP_DISPLAY_ID;
    end else if (loc_dev == local_mem_reg[mem_index(GRP_LINK_CTRL,
                 EXT_COLOUR_ADDR_OFFSET)][6:0]) begin
      loc_hit_grp = GRP_EXT_COLOUR;
    end else begin
      loc_hit = 1'b0;
    end
  end

  always_comb begin
    if (loc_grp_reg == GRP_LOW_LEVEL &&
        loc_ptr[2:0] == LOW_STATUS_OFFSET) begin
      loc_rdata = 8'h00;
      loc_rdata[SYNC_DETECT_BIT]  = sync_det_s;
      loc_rdata[CLOCK_DETECT_BIT] = clk_det_s;
    end else if (loc_grp_reg == GRP_LOW_LEVEL &&
                 loc_ptr[2:0] == LOW_SOFT_RST_OFFSET) begin
      loc_rdata = 8'h00;
    end else begin
      loc_rdata = local_mem_reg[mem_index(loc_grp_reg, loc_ptr[2:0])];
    end
  end

  // oversampling at 10 MHz leaves 25 core cycles per 400 kHz bit
  disp_i2c_engine #(
    .SHORT_READ (1'b0),
    .PTR_INIT   (8'h00),
    .PTR_RELOAD (1'b0)
  ) u_local (
    .core_clk_i   (core_clk_i),
    .reset_i      (reset_i),
    .scl_i        (loc_scl_s),
    .sda_i        (loc_sda_s),
    .soft_reset_i (1'b0),
    .addr_hit_i   (loc_hit),
    .rdata_i      (loc_rdata),
    .dev_addr_o   (loc_dev),
    .addr_take_o  (loc_take),
    .wr_stb_o     (loc_wr),
    .rd_stb_o     (),
    .ptr_o        (loc_ptr),
    .wdata_o      (loc_wdata),
    .sda_oe_o     (local_serial_data_pin_oe_o)
  );

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      loc_grp_reg <= GRP_LINK_CTRL;
    end else if (loc_take) begin
      loc_grp_reg <= loc_hit_grp;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      for (int i = 0; i < GROUP_COUNT*GROUP_BYTES; i++) begin
        local_mem_reg[i] <= 8'h00;
      end
      local_mem_reg[mem_index(GRP_LINK_CTRL, CONSUMER_ADDR_OFFSET)]
        <= CONSUMER_ADDR_RESET;
      local_mem_reg[mem_index(GRP_LINK_CTRL, DISPLAY_ID_ADDR_OFFSET)]
        <= DISPLAY_ID_ADDR_RESET;
      local_mem_reg[mem_index(GRP_LINK_CTRL, EXT_COLOUR_ADDR_OFFSET)]
        <= EXT_COLOUR_ADDR_RESET;
    end else if (loc_wr && !(loc_grp_reg == GRP_LOW_LEVEL &&
                 loc_ptr[2:0] <= LOW_SOFT_RST_OFFSET)) begin
      local_mem_reg[mem_index(loc_grp_reg, loc_ptr[2:0])]
        <= loc_wdata;
    end
  end

  // software reset is a one-cycle pulse that homes the channel pointer
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      soft_reset_reg <= 1'b0;
    end else begin
      soft_reset_reg <= loc_wr && loc_grp_reg == GRP_LOW_LEVEL &&
                        loc_ptr[2:0] == LOW_SOFT_RST_OFFSET &&
                        loc_wdata[SOFT_RESET_BIT];
    end
  end

  // open-drain pins only ever pull low
  always_ff @(posedge core_clk_i) begin
    channel_serial_data_pin_o <= 1'b0;
    local_serial_data_pin_o   <= 1'b0;
  end

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (reset_i);

  AST_CHAN_ADDR: assert property (
    chan_take |-> chan_dev == CHAN_DEV_ADDR)
    else $error("channel port took a foreign address");

  AST_STRAP_HOLD: assert property (
    strap_done_reg && $past(strap_done_reg) |-> $stable(strap_reg) &&
    $stable(link_ctrl_addr) && $stable(low_level_addr))
    else $error("strap addresses moved after reset");

  AST_STRAP_MAP: assert property (
    loc_take && loc_hit_grp == GRP_LOW_LEVEL |->
    loc_dev == (strap_reg ? LOW_LEVEL_ADDR_HI : LOW_LEVEL_ADDR_LO))
    else $error("low-level group taken at wrong address");

  AST_SOFT_HOME: assert property (
    soft_reset_reg |=> chan_ptr == CHAN_PTR_RESET)
    else $error("software reset did not home channel pointer");

  AST_PORT_APART: assert property (
    loc_wr && !soft_reset_reg && $stable(chan_scl_s) &&
    $stable(chan_sda_s) |=> $stable(chan_ptr))
    else $error("local traffic moved the channel pointer");

endmodule : disp_i2c_ports

// ### disp_bus_master.sv
// serial bus master model standing in for the far side of one port
`timescale 1ns/1ps
module disp_bus_master #(
  parameter int HALF_CYC = 13
) (
  input  wire logic core_clk_i,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_oe_o
);
  // 26 core cycles a bit keeps the link below 400 kHz and gives the
  // slave's synchronizers room to answer within each phase
  initial begin
    scl_o = 1'b1;
    sda_oe_o = 1'b0;
  end

  task automatic pause(input int n);
    repeat (n) @(negedge core_clk_i);
  endtask : pause

  // data moves mid low phase and is sampled mid high phase
  task automatic bit_io(input logic b, output logic s);
    pause(6);
    sda_oe_o = ~b;
    pause(HALF_CYC - 6);
    scl_o = 1'b1;
    pause(6);
    s = sda_i;
    pause(HALF_CYC - 6);
    scl_o = 1'b0;
  endtask : bit_io

  task automatic start();
    if (!scl_o) begin
      pause(6);
      sda_oe_o = 1'b0;
      pause(HALF_CYC - 6);
      scl_o = 1'b1;
    end
    pause(HALF_CYC);
    sda_oe_o = 1'b1;
    pause(HALF_CYC);
    scl_o = 1'b0;
  endtask : start

  task automatic stop();
    pause(6);
    sda_oe_o = 1'b1;
    pause(HALF_CYC - 6);
    scl_o = 1'b1;
    pause(HALF_CYC);
    sda_oe_o = 1'b0;
    pause(HALF_CYC);
  endtask : stop

  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], s);
    end
    bit_io(1'b1, s);
    ack = ~s;
  endtask : wbyte

  task automatic rbyte(input logic ack, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, b[i]);
    end
    bit_io(~ack, s);
  endtask : rbyte

  task automatic probe(input logic [6:0] a, output logic ack);
    start();
    wbyte({a, 1'b0}, ack);
    stop();
  endtask : probe

  task automatic write_regs(input logic [6:0] a, input logic [7:0] p,
                            input logic [15:0] d, output logic ok);
    logic k0, k1, k2, k3;
    start();
    wbyte({a, 1'b0}, k0);
    wbyte(p, k1);
    wbyte(d[7:0], k2);
    wbyte(d[15:8], k3);
    stop();
    ok = k0 & k1 & k2 & k3;
  endtask : write_regs

  // the short form skips the pointer phase: the cheap way to poll the
  // link integrity value
  task automatic read_regs(input logic [6:0] a, input logic [7:0] p,
                           input logic short_rd, output logic [15:0] d,
                           output logic ok);
    logic k0, k1, k2;
    k0 = 1'b1;
    k1 = 1'b1;
    start();
    if (!short_rd) begin
      wbyte({a, 1'b0}, k0);
      wbyte(p, k1);
      start();
    end
    wbyte({a, 1'b1}, k2);
    rbyte(1'b1, d[7:0]);
    rbyte(1'b0, d[15:8]);
    stop();
    ok = k0 & k1 & k2;
  endtask : read_regs
endmodule : disp_bus_master

// ### dual_i2c_slave_ports_bench.sv
// self-checking bench for the dual serial slave ports
`timescale 1ns/1ps
`define CHK(got, exp) \
  begin \
    checked++; \
    if ((got) !== (exp)) begin \
      bad_count++; \
      $display("MISMATCH t=%0t got=%h exp=%h", $time, (got), (exp)); \
    end \
  end
module dual_i2c_slave_ports_bench
  import disp_pkg::*;
;
  logic        core_clk_i;
  logic        reset_i;
  logic        strap;
  logic        ch_scl, ch_sda, ch_o, ch_oe, ch_m_oe;
  logic        lc_scl, lc_sda, lc_o, lc_oe, lc_m_oe;
  logic [15:0] liv;
  logic        sync_flag, clk_flag;
  logic [15:0] d;
  logic        ok;
  int          checked, bad_count;

  // both buses are open drain with pull-ups
  assign ch_sda = (ch_oe ? ch_o : 1'b1) & ~ch_m_oe;
  assign lc_sda = (lc_oe ? lc_o : 1'b1) & ~lc_m_oe;

  disp_i2c_ports i_dut (
    .core_clk_i(core_clk_i),
    .reset_i(reset_i),
    .address_strap_pin_i(strap),
    .channel_serial_clock_pin_i(ch_scl),
    .channel_serial_data_pin_i(ch_sda),
    .channel_serial_data_pin_o(ch_o),
    .channel_serial_data_pin_oe_o(ch_oe),
    .local_serial_clock_pin_i(lc_scl),
    .local_serial_data_pin_i(lc_sda),
    .local_serial_data_pin_o(lc_o),
    .local_serial_data_pin_oe_o(lc_oe),
    .link_integrity_value_i(liv),
    .sync_detect_flag_i(sync_flag),
    .clock_detect_flag_i(clk_flag)
  );
  disp_bus_master i_ch (.core_clk_i(core_clk_i), .sda_i(ch_sda),
                        .scl_o(ch_scl), .sda_oe_o(ch_m_oe));
  disp_bus_master i_loc (.core_clk_i(core_clk_i), .sda_i(lc_sda),
                         .scl_o(lc_scl), .sda_oe_o(lc_m_oe));

  initial begin
    core_clk_i = 1'b0;
    forever #50 core_clk_i = ~core_clk_i;
  end

  task automatic results();
    $display("checked=%0d bad_count=%0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : results

  // strap is held across the release so the sampled level is clean
  task automatic do_reset(input logic s);
    strap = s;
    reset_i = 1'b1;
    repeat (6) @(negedge core_clk_i);
    reset_i = 1'b0;
    repeat (8) @(negedge core_clk_i);
  endtask : do_reset

  task automatic probe_chk(input logic lc, input logic [6:0] a,
                           input logic exp);
    logic k;
    if (lc) i_loc.probe(a, k);
    else i_ch.probe(a, k);
    `CHK(k, exp)
  endtask : probe_chk

  task automatic t_channel();
    liv = 16'hc35a;
    i_ch.read_regs(7'h74, 8'h00, 1'b1, d, ok);
    `CHK(ok, 1'b1)
    `CHK(d, 16'hc35a)
    i_ch.write_regs(7'h74, 8'h02, 16'hbeef, ok);
    `CHK(ok, 1'b1)
    i_ch.write_regs(7'h74, 8'h08, 16'h1234, ok);
    i_ch.read_regs(7'h74, 8'h00, 1'b1, d, ok);
    `CHK(d, 16'hc35a)
    i_ch.read_regs(7'h74, 8'h02, 1'b0, d, ok);
    `CHK(d, 16'hbeef)
  endtask : t_channel

  task automatic t_local();
    i_loc.read_regs(7'h60, 8'h00, 1'b0, d, ok);
    `CHK(ok, 1'b1)
    `CHK(d, 16'h5034)
    i_loc.read_regs(7'h60, 8'h00, 1'b1, d, ok);
    `CHK(ok, 1'b0)
    clk_flag = 1'b1;
    i_loc.read_regs(7'h68, 8'h00, 1'b0, d, ok);
    `CHK(d, 16'h0002)
    sync_flag = 1'b1;
    clk_flag = 1'b0;
    i_loc.read_regs(7'h68, 8'h00, 1'b0, d, ok);
    `CHK(d, 16'h0001)
    // software reset pulse; the channel pointer is home again after it
    i_loc.write_regs(7'h68, 8'h01, 16'h0001, ok);
    `CHK(ok, 1'b1)
    i_ch.read_regs(7'h74, 8'h00, 1'b1, d, ok);
    `CHK(d, liv)
  endtask : t_local

  task automatic t_relocate();
    i_loc.write_regs(7'h60, 8'h00, 16'h503c, ok);
    `CHK(ok, 1'b1)
    probe_chk(1'b1, 7'h3c, 1'b1);
    probe_chk(1'b1, 7'h34, 1'b0);
    probe_chk(1'b1, 7'h50, 1'b1);
    probe_chk(1'b1, 7'h32, 1'b1);
    i_loc.write_regs(7'h3c, 8'h03, 16'h9911, ok);
    i_loc.read_regs(7'h3c, 8'h03, 1'b0, d, ok);
    `CHK(d, 16'h9911)
    i_loc.read_regs(7'h50, 8'h03, 1'b0, d, ok);
    `CHK(d, 16'h0000)
    i_ch.read_regs(7'h74, 8'h00, 1'b1, d, ok);
    `CHK(d, liv)
  endtask : t_relocate

  task automatic t_unknown();
    probe_chk(1'b0, 7'h50, 1'b0);
    probe_chk(1'b0, 7'h60, 1'b0);
    probe_chk(1'b1, 7'h74, 1'b0);
    probe_chk(1'b1, 7'h62, 1'b0);
  endtask : t_unknown

  task automatic t_strap();
    strap = 1'b1;
    probe_chk(1'b1, 7'h60, 1'b1);
    probe_chk(1'b1, 7'h6a, 1'b0);
    do_reset(1'b1);
    probe_chk(1'b1, 7'h62, 1'b1);
    probe_chk(1'b1, 7'h6a, 1'b1);
    probe_chk(1'b1, 7'h68, 1'b0);
    probe_chk(1'b1, 7'h34, 1'b1);
  endtask : t_strap

  initial begin
    reset_i = 1'b1;
    strap = 1'b0;
    liv = 16'h0000;
    sync_flag = 1'b0;
    clk_flag = 1'b0;
    checked = 0;
    bad_count = 0;
    do_reset(1'b0);
    t_channel();
    t_local();
    t_relocate();
    t_unknown();
    t_strap();
    results();
  end

  // a hung bus ends the run as a failure
  initial begin
    repeat (60000) @(posedge core_clk_i);
    bad_count++;
    results();
  end
endmodule : dual_i2c_slave_ports_bench
